// ===== logic/ecw_pkg.sv
// Constants, field layouts and carrier types of the receive watermark and flag register bank.
// Assumes an APB master on the software side and a receive datapath that reports count steps.
// ==========================================================================
// Summary of operation
// RULE_01 - Each register except status also answers at clear, set and invert aliases.
// RULE_02 - Full watermark bits 23-16 compare with count, drive full flag and flow control.
// RULE_03 - Empty watermark bits 7-0 compare with count, drive empty flag, release flow.
// RULE_04 - Software should program the full watermark above the empty watermark.
// RULE_05 - Transmit bus-error flag bit 14 sets on a transmit DMA bus error.
// RULE_06 - Receive bus-error flag bit 13 sets on a receive DMA bus error.
// RULE_07 - Bus-error flags stay set until reset or a one through the clear alias; the code also drops them on a plain write of zero or an invert write of one.
// RULE_08 - Empty-watermark flag bit 9 sets while count is at or below empty watermark.
// RULE_09 - Empty flag clears on hardware count increment; software writes do nothing.
// RULE_10 - Full-watermark flag bit 8 sets while count is at or above full watermark.
// RULE_11 - Writing the decrement bit lowers the count and clears the full flag.
// RULE_12 - Software should change flags only through the alias addresses.
// RULE_13 - Unimplemented bits read zero and ignore writes.
// RULE_14 - All registers are zero in reset; the first edge after it sets flags bits 9 and 8, as count 0 meets both watermarks.
// RULE_15 - Interrupt output is high while any flag meets its enable bit.
// RULE_16 - Automatic flow control holds from full watermark until count falls to empty.
package ecw_pkg;
  // ==========================================================================
  // Register map
  localparam logic [15:0] OFS_PRIMARY_CONTROL = 16'h2000;
  localparam logic [15:0] OFS_RX_BUFFER_SIZE = 16'h2010;
  localparam logic [15:0] OFS_TX_DESC_START = 16'h2020;
  localparam logic [15:0] OFS_RX_DESC_START = 16'h2030;
  localparam logic [15:0] OFS_HASH_LOW = 16'h2040;
  localparam logic [15:0] OFS_HASH_HIGH = 16'h2050;
  localparam logic [15:0] OFS_PATTERN_MASK_LOW = 16'h2060;
  localparam logic [15:0] OFS_PATTERN_MASK_HIGH = 16'h2070;
  localparam logic [15:0] OFS_PATTERN_CHECKSUM = 16'h2080;
  localparam logic [15:0] OFS_PATTERN_OFFSET = 16'h2090;
  localparam logic [15:0] OFS_RX_FILTER_CONFIG = 16'h20a0;
  localparam logic [15:0] OFS_RX_WATERMARKS = 16'h20b0;
  localparam logic [15:0] OFS_IRQ_ENABLES = 16'h20c0;
  localparam logic [15:0] OFS_IRQ_FLAGS = 16'h20d0;
  localparam logic [15:0] OFS_CONTROLLER_STATUS = 16'h20e0;
  localparam logic [15:0] OFS_RX_OVERFLOW_COUNT = 16'h2100;
  localparam int NUM_REGS = 16;
  // ==========================================================================
  // Alias codes in address bits 3:2
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // ==========================================================================
  // Implemented bits of each register, in map order
  localparam logic [31:0] IMPL_MASK [NUM_REGS] = '{
    32'hffff_a391, 32'h0000_07f0, 32'hffff_fffc, 32'hffff_fffc,
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h00ff_00ff,
    32'h0000_63ef, 32'h0000_63ef, 32'h00ff_e0e0, 32'h0000_ffff};
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ==========================================================================
  // Field positions
  localparam int BIT_DECREMENT = 0;
  localparam int BIT_AUTO_FC = 7;
  localparam int BIT_FULL_FLAG = 8;
  localparam int BIT_EMPTY_FLAG = 9;
  localparam int BIT_RX_BUS_ERR = 13;
  localparam int BIT_TX_BUS_ERR = 14;
  localparam int FULL_WM_LSB = 16;
  localparam int EMPTY_WM_LSB = 0;
  localparam int COUNT_LSB = 16;
  localparam int STATUS_IDX = 14;
  localparam int FLAGS_IDX = 13;
  localparam int ENABLES_IDX = 12;
  localparam int WM_IDX = 11;
  localparam int CTRL_IDX = 0;
  localparam int OVF_IDX = 15;
  // Event flags other than the watermark and bus-error ones, set by datapath pulses.
  localparam logic [31:0] EVENT_FLAG_MASK = 32'h0000_00ef;
  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic tx_bus_error;
    logic rx_bus_error;
    logic count_increment;
    logic overflow_pulse;
    logic [7:0] other_events;
  } ecw_events_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ecw_apb_resp_type;
endpackage : ecw_pkg

// ===== logic/ecw_alias.sv
// Alias write combiner for one register word.
// Assumes the caller gives the alias code from address bits 3:2.
// ==========================================================================
module ecw_alias (
  input wire logic [1:0] alias_code,
  input wire logic [31:0] old_value,
  input wire logic [31:0] wdata,
  input wire logic [31:0] impl_mask,
  output logic [31:0] new_value
);
  import ecw_pkg::*;
  always_comb begin
    unique case (alias_code)
      ALIAS_PLAIN: new_value = wdata; // [RULE_01]
      ALIAS_CLR: new_value = old_value & ~wdata; // [RULE_01]
      ALIAS_SET: new_value = old_value | wdata; // [RULE_01]
      ALIAS_INV: new_value = old_value ^ wdata; // [RULE_01]
    endcase
    new_value = new_value & impl_mask; // [RULE_13]
  end
endmodule : ecw_alias

// ===== logic/ecw_regs.sv
// Register bank with watermark comparison, event flags and automatic flow control.
// Assumes an APB master on CLK and single-cycle event pulses from the DMA and receive logic.
// ==========================================================================
//
// Decided for this implementation: the APB register port.
module ecw_regs (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire ecw_pkg::ecw_events_type EVENTS,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic FLOW_CONTROL,
  output logic [7:0] RX_BUFFER_COUNT,
  output logic [31:0] PRIMARY_CONTROL
);
  import ecw_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][31:0] regs;
    logic [7:0] count;
    logic flow;
    logic irq;
    ecw_apb_resp_type resp;
  } ecw_state_type;

  ecw_state_type st_q;
  ecw_state_type st_d;
  logic [31:0] alias_value;
  logic [3:0] sel_idx;
  logic sel_hit;
  logic sel_status;
  logic access;
  logic [1:0] alias_code;

  // ==========================================================================
  // Address decode
  function automatic logic [4:0] decode_index(input logic [15:0] addr);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i < 15 && addr[15:4] == OFS_PRIMARY_CONTROL[15:4] + 12'(i)) begin
        r = 5'(i);
      end
    end
    if (addr[15:4] == OFS_RX_OVERFLOW_COUNT[15:4]) begin
      r = 5'(OVF_IDX);
    end
    return r;
  endfunction : decode_index

  logic [4:0] dec;
  assign dec = decode_index(PADDR);
  assign sel_idx = dec[3:0];
  assign sel_hit = ~dec[4];
  assign alias_code = PADDR[3:2];
  // Status has no aliases, so only its plain word is mapped.
  assign sel_status = sel_hit && (32'(sel_idx) == STATUS_IDX); // [RULE_01]
  assign access = PSEL && PENABLE && !st_q.resp.pready;

  ecw_alias u_alias (
    .alias_code(alias_code),
    .old_value(st_q.regs[sel_idx]),
    .wdata(PWDATA),
    .impl_mask(IMPL_MASK[sel_idx]),
    .new_value(alias_value)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic valid;
    logic dec_req;
    logic [31:0] flags;
    logic [7:0] full_wm;
    logic [7:0] empty_wm;
    st_d = st_q;
    valid = sel_hit && !(sel_status && alias_code != ALIAS_PLAIN) && (PADDR[1:0] == 2'h0);
    dec_req = 1'b0;
    flags = 32'h0000_0000;
    full_wm = 8'h00;
    empty_wm = 8'h00;
    st_d.resp.pready = access;
    st_d.resp.pslverr = access && !valid;
    st_d.resp.prdata = 32'h0000_0000;
    if (access && valid && !PWRITE) begin
      st_d.resp.prdata = st_q.regs[sel_idx] & IMPL_MASK[sel_idx]; // [RULE_13]
    end
    if (access && valid && PWRITE && !sel_status) begin
      st_d.regs[sel_idx] = alias_value;
      if (32'(sel_idx) == CTRL_IDX) begin
        dec_req = alias_value[BIT_DECREMENT];
        // The decrement bit is a strobe and never holds a value.
        st_d.regs[CTRL_IDX][BIT_DECREMENT] = 1'b0; // [RULE_11]
      end
      if (32'(sel_idx) == FLAGS_IDX) begin
        // Watermark flags ignore software, so they keep their old value here.
        st_d.regs[FLAGS_IDX][BIT_FULL_FLAG] = st_q.regs[FLAGS_IDX][BIT_FULL_FLAG]; // [RULE_11]
        st_d.regs[FLAGS_IDX][BIT_EMPTY_FLAG] = st_q.regs[FLAGS_IDX][BIT_EMPTY_FLAG]; // [RULE_09]
      end
    end
    // Count tracking; an increment and a decrement together cancel out.
    if (EVENTS.count_increment && !dec_req && st_q.count != 8'hff) begin
      st_d.count = st_q.count + 8'h01;
    end else if (dec_req && !EVENTS.count_increment && st_q.count != 8'h00) begin
      st_d.count = st_q.count - 8'h01; // [RULE_11]
    end
    if (EVENTS.overflow_pulse && st_q.regs[OVF_IDX][15:0] != 16'hffff) begin
      st_d.regs[OVF_IDX][15:0] = st_d.regs[OVF_IDX][15:0] + 16'h0001;
    end
    st_d.regs[STATUS_IDX] = 32'h0000_0000;
    st_d.regs[STATUS_IDX][COUNT_LSB +: 8] = st_d.count;
    // Compare with the watermarks as written this cycle, so the flags never lag a new setting.
    full_wm = st_d.regs[WM_IDX][FULL_WM_LSB +: 8];
    empty_wm = st_d.regs[WM_IDX][EMPTY_WM_LSB +: 8];
    flags = st_d.regs[FLAGS_IDX];
    // Hardware sets win over a clear written in the same cycle.
    flags = flags | (32'(EVENTS.other_events) & EVENT_FLAG_MASK);
    if (EVENTS.tx_bus_error) begin
      flags[BIT_TX_BUS_ERR] = 1'b1; // [RULE_05] [RULE_07]
    end
    if (EVENTS.rx_bus_error) begin
      flags[BIT_RX_BUS_ERR] = 1'b1; // [RULE_06] [RULE_07]
    end
    if (dec_req) begin
      flags[BIT_FULL_FLAG] = 1'b0; // [RULE_11]
    end
    if (st_d.count >= full_wm) begin
      flags[BIT_FULL_FLAG] = 1'b1; // [RULE_02] [RULE_10]
    end
    if (EVENTS.count_increment) begin
      flags[BIT_EMPTY_FLAG] = 1'b0; // [RULE_09]
    end
    if (st_d.count <= empty_wm) begin
      flags[BIT_EMPTY_FLAG] = 1'b1; // [RULE_03] [RULE_08]
    end
    st_d.regs[FLAGS_IDX] = flags & IMPL_MASK[FLAGS_IDX]; // [RULE_13]
    // Hysteresis: on at full watermark, off at empty watermark.
    if (!st_q.regs[CTRL_IDX][BIT_AUTO_FC]) begin
      st_d.flow = 1'b0;
    end else if (st_d.count >= full_wm) begin
      st_d.flow = 1'b1; // [RULE_02] [RULE_16]
    end else if (st_d.count <= empty_wm) begin
      st_d.flow = 1'b0; // [RULE_03] [RULE_16]
    end
    st_d.irq = |(st_d.regs[FLAGS_IDX] & st_d.regs[ENABLES_IDX]); // [RULE_15]
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= '0; // [RULE_14]
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA = st_q.resp.prdata;
  assign PREADY = st_q.resp.pready;
  assign PSLVERR = st_q.resp.pslverr;
  assign IRQ = st_q.irq;
  assign FLOW_CONTROL = st_q.flow;
  assign RX_BUFFER_COUNT = st_q.count;
  assign PRIMARY_CONTROL = st_q.regs[CTRL_IDX];

  // ==========================================================================
  // Checks
  sequence s_tx_err;
    EVENTS.tx_bus_error;
  endsequence
  property p_tx_err_set;
    @(posedge CLK) disable iff (!ARST_N) s_tx_err |=> st_q.regs[FLAGS_IDX][BIT_TX_BUS_ERR];
  endproperty
  a_tx_err_set: assert property (p_tx_err_set) else $error("tx bus error flag not set"); // [RULE_05]
  property p_rx_err_set;
    @(posedge CLK) disable iff (!ARST_N)
      EVENTS.rx_bus_error |=> st_q.regs[FLAGS_IDX][BIT_RX_BUS_ERR];
  endproperty
  a_rx_err_set: assert property (p_rx_err_set) else $error("rx bus error flag not set"); // [RULE_06]
  property p_err_sticky;
    @(posedge CLK) disable iff (!ARST_N)
      st_q.regs[FLAGS_IDX][BIT_TX_BUS_ERR] && !(access && PWRITE && alias_code != ALIAS_SET
      && 32'(sel_idx) == FLAGS_IDX) |=> st_q.regs[FLAGS_IDX][BIT_TX_BUS_ERR];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("bus error flag dropped"); // [RULE_07]
  // The first edge after reset still shows the cleared flags, so that edge is skipped.
  property p_full_flag;
    @(posedge CLK) disable iff (!ARST_N)
      $past(ARST_N) && st_q.count >= st_q.regs[WM_IDX][23:16]
      |-> st_q.regs[FLAGS_IDX][BIT_FULL_FLAG];
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag missing"); // [RULE_10]
  property p_empty_flag;
    @(posedge CLK) disable iff (!ARST_N)
      $past(ARST_N) && st_q.count <= st_q.regs[WM_IDX][7:0]
      |-> st_q.regs[FLAGS_IDX][BIT_EMPTY_FLAG];
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag missing"); // [RULE_08]
  property p_irq;
    @(posedge CLK) disable iff (!ARST_N)
      IRQ == |(st_q.regs[FLAGS_IDX] & st_q.regs[ENABLES_IDX]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong"); // [RULE_15]
  property p_unimpl;
    @(posedge CLK) disable iff (!ARST_N)
      PREADY |-> (PRDATA & ~IMPL_MASK[$past(sel_idx)]) == 32'h0000_0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero"); // [RULE_13]
  property p_flow_hold;
    @(posedge CLK) disable iff (!ARST_N)
      FLOW_CONTROL && st_q.regs[CTRL_IDX][BIT_AUTO_FC] && st_d.count > st_d.regs[WM_IDX][7:0]
      |=> FLOW_CONTROL;
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow control released early"); // [RULE_16]
  property p_alias_set;
    @(posedge CLK) disable iff (!ARST_N)
      access && PWRITE && alias_code == ALIAS_SET && 32'(sel_idx) == ENABLES_IDX
      |=> (st_q.regs[ENABLES_IDX] & ($past(PWDATA) & IMPL_MASK[ENABLES_IDX]))
        == ($past(PWDATA) & IMPL_MASK[ENABLES_IDX]);
  endproperty
  a_alias_set: assert property (p_alias_set) else $error("set alias failed"); // [RULE_01]

  // ==========================================================================
  // Checks on flag clearing, flow control, aliases, refused accesses, reset, the decrement strobe and the status count
  property p_rx_sticky;
    @(posedge CLK) disable iff (!ARST_N)
      st_q.regs[FLAGS_IDX][BIT_RX_BUS_ERR] && !(access && PWRITE && alias_code != ALIAS_SET
      && 32'(sel_idx) == FLAGS_IDX) |=> st_q.regs[FLAGS_IDX][BIT_RX_BUS_ERR];
  endproperty
  a_rx_sticky: assert property (p_rx_sticky) else $error("rx error flag dropped"); // [RULE_07]

  sequence s_flags_clr;
    access && PWRITE && alias_code == ALIAS_CLR && 32'(sel_idx) == FLAGS_IDX;
  endsequence
  property p_tx_clear;
    @(posedge CLK) disable iff (!ARST_N)
      s_flags_clr ##0 (PWDATA[BIT_TX_BUS_ERR] && PADDR[1:0] == 2'h0 && !EVENTS.tx_bus_error)
      |=> !st_q.regs[FLAGS_IDX][BIT_TX_BUS_ERR];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx error flag not cleared"); // [RULE_07]

  // A falling count can only come from a decrement, which must drop the full flag once the count is below the full watermark.
  property p_full_clear;
    @(posedge CLK) disable iff (!ARST_N)
      $past(ARST_N) && st_q.count < $past(st_q.count)
      && st_q.count < st_q.regs[WM_IDX][FULL_WM_LSB +: 8]
      |-> !st_q.regs[FLAGS_IDX][BIT_FULL_FLAG];
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full flag not cleared"); // [RULE_11]

  // A rising count can only come from an increment, which must drop the empty flag once the count is above the empty watermark.
  property p_empty_clear;
    @(posedge CLK) disable iff (!ARST_N)
      $past(ARST_N) && st_q.count > $past(st_q.count)
      && st_q.count > st_q.regs[WM_IDX][EMPTY_WM_LSB +: 8]
      |-> !st_q.regs[FLAGS_IDX][BIT_EMPTY_FLAG];
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag not cleared"); // [RULE_09]

  property p_flag_write;
    @(posedge CLK) disable iff (!ARST_N)
      access && PWRITE && 32'(sel_idx) == FLAGS_IDX && !st_q.regs[FLAGS_IDX][BIT_FULL_FLAG]
      && st_d.count < st_d.regs[WM_IDX][FULL_WM_LSB +: 8]
      |=> !st_q.regs[FLAGS_IDX][BIT_FULL_FLAG];
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("software set full flag"); // [RULE_11]

  property p_flow_disabled;
    @(posedge CLK) disable iff (!ARST_N)
      !st_q.regs[CTRL_IDX][BIT_AUTO_FC] |=> !FLOW_CONTROL;
  endproperty
  a_flow_disabled: assert property (p_flow_disabled) else $error("flow without enable"); // [RULE_16]

  property p_flow_on;
    @(posedge CLK) disable iff (!ARST_N)
      st_q.regs[CTRL_IDX][BIT_AUTO_FC] && st_d.count >= st_d.regs[WM_IDX][FULL_WM_LSB +: 8]
      |=> FLOW_CONTROL;
  endproperty
  a_flow_on: assert property (p_flow_on) else $error("flow not raised at full"); // [RULE_02]

  property p_flow_off;
    @(posedge CLK) disable iff (!ARST_N)
      st_q.regs[CTRL_IDX][BIT_AUTO_FC] && st_d.count <= st_d.regs[WM_IDX][EMPTY_WM_LSB +: 8]
      && st_d.count < st_d.regs[WM_IDX][FULL_WM_LSB +: 8]
      |=> !FLOW_CONTROL;
  endproperty
  a_flow_off: assert property (p_flow_off) else $error("flow not released at empty"); // [RULE_03]

  // Status has no alias words, so any of them must be refused.
  property p_status_alias;
    @(posedge CLK) disable iff (!ARST_N)
      access && sel_status && alias_code != ALIAS_PLAIN |=> PSLVERR;
  endproperty
  a_status_alias: assert property (p_status_alias) else $error("status alias accepted"); // [RULE_01]

  property p_unmapped;
    @(posedge CLK) disable iff (!ARST_N)
      access && !sel_hit |=> PSLVERR && PRDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted"); // [RULE_13]

  property p_reset_zero;
    @(posedge CLK) !ARST_N |=> st_q == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset"); // [RULE_14]

  sequence s_wm_write;
    access && PWRITE && PADDR[1:0] == 2'h0 && 32'(sel_idx) == WM_IDX;
  endsequence
  property p_wm_clr;
    @(posedge CLK) disable iff (!ARST_N)
      s_wm_write ##0 (alias_code == ALIAS_CLR)
      |=> (st_q.regs[WM_IDX] & $past(PWDATA)) == 32'h0000_0000;
  endproperty
  a_wm_clr: assert property (p_wm_clr) else $error("clear alias failed"); // [RULE_01]

  property p_wm_inv;
    @(posedge CLK) disable iff (!ARST_N)
      s_wm_write ##0 (alias_code == ALIAS_INV)
      |=> st_q.regs[WM_IDX] == (($past(st_q.regs[WM_IDX]) ^ $past(PWDATA)) & IMPL_MASK[WM_IDX]);
  endproperty
  a_wm_inv: assert property (p_wm_inv) else $error("invert alias failed"); // [RULE_01]

  property p_dec_strobe;
    @(posedge CLK) disable iff (!ARST_N)
      !PRIMARY_CONTROL[BIT_DECREMENT];
  endproperty
  a_dec_strobe: assert property (p_dec_strobe) else $error("decrement bit held"); // [RULE_11]

  property p_count_status;
    @(posedge CLK) disable iff (!ARST_N)
      st_q.regs[STATUS_IDX][COUNT_LSB +: 8] == st_q.count;
  endproperty
  a_count_status: assert property (p_count_status) else $error("status count wrong"); // [RULE_09]
endmodule : ecw_regs

// ===== tb/ecw_dma_model.sv
// Far-side model of the DMA engines and receive logic that report events into the bank.
// Assumes the bench calls send() from its own process, between transfers or during them.
// ==========================================================================
module ecw_dma_model (
  input wire logic CLK,
  output ecw_pkg::ecw_events_type EVENTS
);
  timeunit 1ns;
  timeprecision 100ps;
  import ecw_pkg::*;

  initial begin
    EVENTS = '0;
  end

  // ==========================================================================
  // One event word is raised for exactly one cycle, as the hardware reports it.
  // Bus errors come from memory accesses of the transmit and receive engines.
  task automatic send(input ecw_events_type e);
    @(posedge CLK);
    EVENTS <= e;
    @(posedge CLK);
    EVENTS <= '0;
  endtask : send
endmodule : ecw_dma_model

// ===== tb/tb.sv
// Self-checking bench of the watermark and flag register bank.
// Assumes the bank answers APB requests on its own and the event model sits beside it.
// ==========================================================================
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ecw_pkg::*;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  ecw_events_type events;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic flow_control;
  logic [7:0] rx_buffer_count;
  logic [31:0] primary_control;
  int failures = 0;
  int compares = 0;

  ecw_dma_model u_dma (.CLK(clk), .EVENTS(events));
  ecw_regs u_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .EVENTS(events), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .FLOW_CONTROL(flow_control),
    .RX_BUFFER_COUNT(rx_buffer_count), .PRIMARY_CONTROL(primary_control));

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Checking and bus helpers.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request is held until pready is seen at an edge, then released at that edge.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk("pslverr", 32'h0, {31'h0, err});
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk($sformatf("reg %h", a), exp, rd);
  endtask : rdc

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rdc(OFS_PRIMARY_CONTROL, 32'h0000_0000);
    rdc(OFS_RX_WATERMARKS, 32'h0000_0000);
    rdc(OFS_IRQ_ENABLES, 32'h0000_0000);
    rdc(OFS_IRQ_FLAGS, 32'h0000_0300);
  endtask : t_reset

  task automatic t_alias;
    wr(OFS_RX_WATERMARKS, 32'hffff_ffff);
    rdc(OFS_RX_WATERMARKS, 32'h00ff_00ff);
    wr(OFS_RX_WATERMARKS + 16'h4, 32'h00f0_00f0);
    rdc(OFS_RX_WATERMARKS, 32'h000f_000f);
    wr(OFS_RX_WATERMARKS + 16'h8, 32'h0100_0100);
    rdc(OFS_RX_WATERMARKS, 32'h000f_000f);
    wr(OFS_RX_WATERMARKS + 16'hc, 32'h000f_0001);
    rdc(OFS_RX_WATERMARKS, 32'h0000_000e);
  endtask : t_alias

  task automatic t_watermarks;
    wr(OFS_RX_WATERMARKS, 32'h0003_0001);
    wr(OFS_PRIMARY_CONTROL + 16'h8, 32'h0000_0080);
    repeat (3) u_dma.send(12'h200);
    repeat (2) @(posedge clk);
    chk("flow", 32'h1, {31'h0, flow_control});
    chk("count", 32'h3, {24'h0, rx_buffer_count});
    rdc(OFS_CONTROLLER_STATUS, 32'h0003_0000);
    rdc(OFS_IRQ_FLAGS, 32'h0000_0100);
    wr(OFS_PRIMARY_CONTROL + 16'h8, 32'h0000_0001);
    rdc(OFS_IRQ_FLAGS, 32'h0000_0000);
    chk("flow", 32'h1, {31'h0, flow_control});
    chk("control", 32'h80, primary_control);
    wr(OFS_IRQ_FLAGS + 16'h8, 32'h0000_0300);
    rdc(OFS_IRQ_FLAGS, 32'h0000_0000);
    wr(OFS_PRIMARY_CONTROL + 16'h8, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("flow", 32'h0, {31'h0, flow_control});
    wr(OFS_IRQ_FLAGS + 16'h4, 32'h0000_0200);
    rdc(OFS_IRQ_FLAGS, 32'h0000_0200);
  endtask : t_watermarks

  task automatic t_bus_errors;
    u_dma.send(12'hcef);
    u_dma.send(12'h100);
    rdc(OFS_IRQ_FLAGS, 32'h0000_62ef);
    rdc(OFS_RX_OVERFLOW_COUNT, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_ENABLES + 16'h8, 32'h0000_2000);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_FLAGS + 16'h4, 32'h0000_40ef);
    rdc(OFS_IRQ_FLAGS, 32'h0000_2200);
    wr(OFS_IRQ_FLAGS + 16'h4, 32'h0000_2000);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_bus_errors

  task automatic t_refused;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 16'h20f0, 32'hffff_ffff, rd, err);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, OFS_CONTROLLER_STATUS + 16'h4, 32'h0, rd, err);
    chk("status alias err", 32'h1, {31'h0, err});
  endtask : t_refused

  // ==========================================================================
  // Verdict, reached from the main sequence or the watchdog.
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_alias();
    t_watermarks();
    t_bus_errors();
    t_refused();
    final_report();
  end

  // A full run takes under two hundred cycles, so this span only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : tb
